//--- common/msb_pkg.sv
// constants and types of the multidrop scan bridge data registers
package msb_pkg;
  localparam int NUM_LP = 3;
  localparam int SLOT_W = 7;
  localparam int FIFO_W = 1;
  localparam int FIFO_DEPTH = 8;
  // level-2 opcodes
  localparam logic [7:0] OP_SOFT_PARK = 8'h88;
  localparam logic [7:0] OP_SIG_SEL = 8'hc9;
  localparam logic [7:0] OP_SIG_ON = 8'h0c;
  localparam logic [7:0] OP_SIG_OFF = 8'h8d;
  localparam logic [7:0] OP_CNT_SEL = 8'hce;
  localparam logic [7:0] OP_CNT_ON = 8'h0f;
  localparam logic [7:0] OP_CNT_OFF = 8'h90;
  localparam logic [7:0] OP_DEF_BYP = 8'h07;
  localparam logic [7:0] OP_MODE_SEL = 8'h8e;
  localparam logic [7:0] OP_GRP_SEL = 8'h03;
  localparam logic [7:0] OP_BYPASS = 8'hff;
  localparam logic [7:0] OP_SAMPLE = 8'h81;
  localparam logic [7:0] OP_EXTEST = 8'h00;
  localparam logic [7:0] OP_IDCODE = 8'haa;
  localparam logic [7:0] OP_UNPARK = 8'he7;
  // addressing
  localparam logic [7:0] ADDR_INDIV_MAX = 8'h3a;
  localparam logic [7:0] ADDR_BCAST = 8'h3b;
  localparam logic [7:0] ADDR_GROUP_BASE = 8'h3c;
  localparam logic [1:0] IR_CAP_TAIL = 2'h1;
  localparam logic [7:0] IR_RESET = 8'h01;
  // reset values and the signature polynomial
  localparam logic [1:0] GROUP_RESET = 2'h0;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [15:0] SIG_RESET = 16'h0000;
  localparam logic [15:0] SIG_POLY = 16'h100b;
  localparam logic [31:0] CNT_RESET = 32'h00000000;
  localparam logic [31:0] ID_CODE = 32'h10000001; // arbitrary value
  // mode register bit positions
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_LOOP_BIT = 4;
  // local clock stop in parked reset state
  localparam logic [9:0] TLR_STOP_PULSES = 10'h200;
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } msb_tap_t;
  typedef enum logic [6:0] {
    DR_BYP = 7'h01, DR_BSR = 7'h02, DR_ID = 7'h04, DR_SIG = 7'h08,
    DR_CNT = 7'h10, DR_GRP = 7'h20, DR_MODE = 7'h40
  } msb_dr_t;
  typedef enum logic [2:0] {
    LP_TLR = 3'h1, LP_RTI = 3'h2, LP_ACT = 3'h4
  } msb_lp_t;
endpackage

//--- common/msb_stream_if.sv
// valid/ready stream between the bridge and its sample queue
`timescale 1ns/100ps
interface msb_stream_if #(parameter int W = 1);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- hdl/msb_bridge.sv
// multidrop scan bridge: level-2 instructions, data registers and chain routing
`timescale 1ns/100ps
module msb_bridge (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic tckB,
  input wire logic tmsB,
  input wire logic tdiB,
  input wire logic [6:0] slotIn,
  input wire logic outEnN,
  input wire logic [2:0] tdoL,
  output logic tdoB,
  output logic tdoBOe,
  output logic [2:0] tckL,
  output logic [2:0] tmsL,
  output logic [2:0] tdiL
);
  localparam int NLP = msb_pkg::NUM_LP;

  function automatic msb_pkg::msb_tap_t tap_next(input msb_pkg::msb_tap_t s, input logic m);
    case (s)
      msb_pkg::TAP_TLR: tap_next = m ? msb_pkg::TAP_TLR : msb_pkg::TAP_RTI;
      msb_pkg::TAP_RTI: tap_next = m ? msb_pkg::TAP_SEL_DR : msb_pkg::TAP_RTI;
      msb_pkg::TAP_SEL_DR: tap_next = m ? msb_pkg::TAP_SEL_IR : msb_pkg::TAP_CAP_DR;
      msb_pkg::TAP_CAP_DR: tap_next = m ? msb_pkg::TAP_EX1_DR : msb_pkg::TAP_SH_DR;
      msb_pkg::TAP_SH_DR: tap_next = m ? msb_pkg::TAP_EX1_DR : msb_pkg::TAP_SH_DR;
      msb_pkg::TAP_EX1_DR: tap_next = m ? msb_pkg::TAP_UPD_DR : msb_pkg::TAP_PAU_DR;
      msb_pkg::TAP_PAU_DR: tap_next = m ? msb_pkg::TAP_EX2_DR : msb_pkg::TAP_PAU_DR;
      msb_pkg::TAP_EX2_DR: tap_next = m ? msb_pkg::TAP_UPD_DR : msb_pkg::TAP_SH_DR;
      msb_pkg::TAP_UPD_DR: tap_next = m ? msb_pkg::TAP_SEL_DR : msb_pkg::TAP_RTI;
      msb_pkg::TAP_SEL_IR: tap_next = m ? msb_pkg::TAP_TLR : msb_pkg::TAP_CAP_IR;
      msb_pkg::TAP_CAP_IR: tap_next = m ? msb_pkg::TAP_EX1_IR : msb_pkg::TAP_SH_IR;
      msb_pkg::TAP_SH_IR: tap_next = m ? msb_pkg::TAP_EX1_IR : msb_pkg::TAP_SH_IR;
      msb_pkg::TAP_EX1_IR: tap_next = m ? msb_pkg::TAP_UPD_IR : msb_pkg::TAP_PAU_IR;
      msb_pkg::TAP_PAU_IR: tap_next = m ? msb_pkg::TAP_EX2_IR : msb_pkg::TAP_PAU_IR;
      msb_pkg::TAP_EX2_IR: tap_next = m ? msb_pkg::TAP_UPD_IR : msb_pkg::TAP_SH_IR;
      msb_pkg::TAP_UPD_IR: tap_next = m ? msb_pkg::TAP_SEL_DR : msb_pkg::TAP_RTI;
      default: tap_next = msb_pkg::TAP_TLR;
    endcase
  endfunction

  // pin synchronisers
  logic [13:0] pinRaw;
  logic [13:0] pinSync;
  logic tckS;
  logic tmsS;
  logic tdiS;
  logic oeS;
  logic [6:0] slotS;
  logic [2:0] tdoS;
  assign pinRaw = {tdoL, outEnN, slotIn, tdiB, tmsB, tckB};
  msb_sync #(.W(14)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );
  assign {tdoS, oeS, slotS, tdiS, tmsS, tckS} = pinSync;

  // sample queue between chain tap and compactor
  msb_stream_if #(.W(msb_pkg::FIFO_W)) qIn ();
  msb_stream_if #(.W(msb_pkg::FIFO_W)) qOut ();
  msb_fifo #(.W(msb_pkg::FIFO_W), .DEPTH(msb_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .inPort(qIn.snk),
    .outPort(qOut.src)
  );

  // backplane clock edges; a rise waits while the queue is full
  logic tckPrev_reg;
  logic tckDly_reg;
  logic pendRise_reg;
  logic rawRise;
  logic rise;
  logic fall;
  assign rawRise = tckS & ~tckPrev_reg;
  assign fall = ~tckS & tckPrev_reg;
  assign rise = (rawRise | pendRise_reg) & qIn.ready;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tckPrev_reg <= 1'b0;
      tckDly_reg <= 1'b0;
      pendRise_reg <= 1'b0;
    end else begin
      tckPrev_reg <= tckS;
      tckDly_reg <= tckPrev_reg;
      pendRise_reg <= (rawRise | pendRise_reg) & ~qIn.ready;
    end
  end

  // tap state tracking
  msb_pkg::msb_tap_t tap_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tap_reg <= msb_pkg::TAP_TLR;
    end else if (rise) begin
      tap_reg <= tap_next(tap_reg, tmsS);
    end
  end

  logic clr;
  logic capIr;
  logic shIr;
  logic updIr;
  logic capDr;
  logic shDr;
  logic updDr;
  logic drBusy;
  logic shifting;
  assign clr = srst | (tap_reg == msb_pkg::TAP_TLR);
  assign capIr = rise & (tap_reg == msb_pkg::TAP_CAP_IR);
  assign shIr = rise & (tap_reg == msb_pkg::TAP_SH_IR);
  assign updIr = fall & (tap_reg == msb_pkg::TAP_UPD_IR);
  assign capDr = rise & (tap_reg == msb_pkg::TAP_CAP_DR);
  assign shDr = rise & (tap_reg == msb_pkg::TAP_SH_DR);
  assign updDr = fall & (tap_reg == msb_pkg::TAP_UPD_DR);
  assign shifting = (tap_reg == msb_pkg::TAP_SH_DR) || (tap_reg == msb_pkg::TAP_SH_IR);
  assign drBusy = tap_reg inside {msb_pkg::TAP_CAP_DR, msb_pkg::TAP_SH_DR, msb_pkg::TAP_EX1_DR,
    msb_pkg::TAP_PAU_DR, msb_pkg::TAP_EX2_DR, msb_pkg::TAP_UPD_DR};

  // instruction register and addressing
  logic [7:0] ir_reg;
  logic [7:0] instr_reg;
  logic selected_reg;
  logic [1:0] group_reg;
  logic addrHit;
  logic lvl2Upd;
  assign addrHit = (ir_reg <= msb_pkg::ADDR_INDIV_MAX && ir_reg == {1'b0, slotS})
    || (ir_reg == msb_pkg::ADDR_BCAST)
    || (ir_reg == msb_pkg::ADDR_GROUP_BASE + {6'h00, group_reg});
  assign lvl2Upd = updIr & selected_reg;
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      ir_reg <= msb_pkg::IR_RESET;
    end else if (capIr) begin
      ir_reg <= {slotS[5:0], msb_pkg::IR_CAP_TAIL};
    end else if (shIr) begin
      ir_reg <= {tdiS, ir_reg[7:1]};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      selected_reg <= 1'b0;
      instr_reg <= msb_pkg::OP_IDCODE;
    end else if (updIr) begin
      if (!selected_reg) begin
        selected_reg <= addrHit;
      end else begin
        instr_reg <= ir_reg;
      end
    end
  end

  // level-2 control flags
  logic defBypass_reg;
  logic sigOn_reg;
  logic cntOn_reg;
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      defBypass_reg <= 1'b0;
      sigOn_reg <= 1'b0;
      cntOn_reg <= 1'b0;
    end else if (lvl2Upd) begin
      case (ir_reg)
        msb_pkg::OP_SIG_ON: sigOn_reg <= 1'b1;
        msb_pkg::OP_SIG_OFF: sigOn_reg <= 1'b0;
        msb_pkg::OP_CNT_ON: cntOn_reg <= 1'b1;
        msb_pkg::OP_CNT_OFF: cntOn_reg <= 1'b0;
        msb_pkg::OP_DEF_BYP: defBypass_reg <= 1'b1;
        default: ;
      endcase
    end
  end

  // data register selection
  msb_pkg::msb_dr_t drSel;
  always_comb begin
    case (instr_reg)
      msb_pkg::OP_BYPASS: drSel = msb_pkg::DR_BYP;
      msb_pkg::OP_SAMPLE, msb_pkg::OP_EXTEST: drSel = msb_pkg::DR_BSR;
      msb_pkg::OP_IDCODE: drSel = msb_pkg::DR_ID;
      msb_pkg::OP_SIG_SEL: drSel = msb_pkg::DR_SIG;
      msb_pkg::OP_CNT_SEL: drSel = msb_pkg::DR_CNT;
      msb_pkg::OP_GRP_SEL: drSel = msb_pkg::DR_GRP;
      msb_pkg::OP_MODE_SEL: drSel = msb_pkg::DR_MODE;
      default: drSel = defBypass_reg ? msb_pkg::DR_BYP : msb_pkg::DR_ID;
    endcase
    if (!selected_reg) begin
      drSel = msb_pkg::DR_BYP;
    end
  end

  // bypass, boundary and identification registers
  logic bypass_reg;
  logic [7:0] bsr_reg;
  logic [31:0] id_reg;
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      bypass_reg <= 1'b0;
    end else if (capDr && drSel == msb_pkg::DR_BYP) begin
      bypass_reg <= 1'b0;
    end else if (shDr && drSel == msb_pkg::DR_BYP) begin
      bypass_reg <= tdiS;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      bsr_reg <= 8'h00;
    end else if (capDr && drSel == msb_pkg::DR_BSR) begin
      bsr_reg <= {oeS, slotS};
    end else if (shDr && drSel == msb_pkg::DR_BSR) begin
      bsr_reg <= {tdiS, bsr_reg[7:1]};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      id_reg <= msb_pkg::ID_CODE;
    end else if (capDr && drSel == msb_pkg::DR_ID) begin
      id_reg <= msb_pkg::ID_CODE;
    end else if (shDr && drSel == msb_pkg::DR_ID) begin
      id_reg <= {tdiS, id_reg[31:1]};
    end
  end

  // group register
  logic [1:0] grpSh_reg;
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      grpSh_reg <= msb_pkg::GROUP_RESET;
      group_reg <= msb_pkg::GROUP_RESET;
    end else if (capDr && drSel == msb_pkg::DR_GRP) begin
      grpSh_reg <= group_reg;
    end else if (shDr && drSel == msb_pkg::DR_GRP) begin
      grpSh_reg <= {tdiS, grpSh_reg[1]};
    end else if (updDr && drSel == msb_pkg::DR_GRP) begin
      group_reg <= grpSh_reg;
    end
  end

  // countdown counter and its status
  logic [31:0] cnt_reg;
  logic cntHold;
  logic cntZero;
  logic cntDone_reg;
  assign cntHold = (drSel == msb_pkg::DR_CNT) & drBusy;
  assign cntZero = (cnt_reg == msb_pkg::CNT_RESET);
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      cnt_reg <= msb_pkg::CNT_RESET;
    end else if (shDr && drSel == msb_pkg::DR_CNT) begin
      cnt_reg <= {tdiS, cnt_reg[31:1]};
    end else if (rise && cntOn_reg && !cntZero && !cntHold) begin
      cnt_reg <= cnt_reg - 32'h00000001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      cntDone_reg <= 1'b0;
    end else if (cntOn_reg && cntZero && !cntHold) begin
      cntDone_reg <= 1'b1;
    end else if (!cntOn_reg || (updDr && drSel == msb_pkg::DR_CNT)) begin
      cntDone_reg <= 1'b0;
    end
  end

  // mode register 0
  logic [6:0] modeCfg_reg;
  logic [7:0] modeSh_reg;
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      modeCfg_reg <= msb_pkg::MODE_RESET[6:0];
      modeSh_reg <= msb_pkg::MODE_RESET;
    end else if (capDr && drSel == msb_pkg::DR_MODE) begin
      modeSh_reg <= {cntDone_reg, modeCfg_reg};
    end else if (shDr && drSel == msb_pkg::DR_MODE) begin
      modeSh_reg <= {tdiS, modeSh_reg[7:1]};
    end else if (updDr && drSel == msb_pkg::DR_MODE) begin
      modeCfg_reg <= modeSh_reg[6:0];
    end
  end

  // signature compactor fed through the sample queue
  logic [15:0] sig_reg;
  logic sigFb;
  assign qIn.valid = (rawRise | pendRise_reg) & (tap_reg == msb_pkg::TAP_SH_DR)
    & sigOn_reg & selected_reg;
  assign qOut.ready = ~((drSel == msb_pkg::DR_SIG) & drBusy);
  assign sigFb = sig_reg[15] ^ qOut.data[0];
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      sig_reg <= msb_pkg::SIG_RESET;
    end else if (shDr && drSel == msb_pkg::DR_SIG) begin
      sig_reg <= {tdiS, sig_reg[15:1]};
    end else if (qOut.valid && qOut.ready) begin
      sig_reg <= {sig_reg[14:0], 1'b0} ^ ({16{sigFb}} & msb_pkg::SIG_POLY);
    end
  end

  // chain routing through the local port network
  logic regOut;
  logic chainOut;
  logic [NLP-1:0] inChain;
  logic [NLP-1:0] srcL;
  logic [NLP-1:0] pad_reg;
  msb_pkg::msb_lp_t lpState_reg [NLP];
  always_comb begin
    case (drSel)
      msb_pkg::DR_BSR: regOut = bsr_reg[0];
      msb_pkg::DR_ID: regOut = id_reg[0];
      msb_pkg::DR_SIG: regOut = sig_reg[0];
      msb_pkg::DR_CNT: regOut = cnt_reg[0];
      msb_pkg::DR_GRP: regOut = grpSh_reg[0];
      msb_pkg::DR_MODE: regOut = modeSh_reg[0];
      default: regOut = bypass_reg;
    endcase
    if (tap_reg == msb_pkg::TAP_SH_IR) begin
      regOut = ir_reg[0];
    end
  end
  always_comb begin
    chainOut = regOut;
    for (int i = 0; i < NLP; i++) begin
      inChain[i] = (lpState_reg[i] == msb_pkg::LP_ACT) && modeCfg_reg[i]
        && !modeCfg_reg[msb_pkg::MODE_LOOP_BIT];
      srcL[i] = chainOut;
      if (inChain[i]) begin
        chainOut = pad_reg[i];
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pad_reg <= '0;
    end else if (rise) begin
      pad_reg <= tdoS;
    end
  end
  // chain output bit seen by the compactor at each shift rise
  assign qIn.data = chainOut;

  // local port controllers
  logic unparkPend_reg;
  always_ff @(posedge clk_sys) begin
    if (clr || (lvl2Upd && ir_reg == msb_pkg::OP_SOFT_PARK)) begin
      unparkPend_reg <= 1'b0;
    end else if (lvl2Upd && ir_reg == msb_pkg::OP_UNPARK) begin
      unparkPend_reg <= 1'b1;
    end else if (rise && tap_reg == msb_pkg::TAP_RTI) begin
      unparkPend_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NLP; i++) begin
      if (clr || (lvl2Upd && ir_reg == msb_pkg::OP_SOFT_PARK)) begin
        lpState_reg[i] <= msb_pkg::LP_TLR;
      end else if (lvl2Upd && ir_reg == msb_pkg::OP_UNPARK
        && lpState_reg[i] == msb_pkg::LP_TLR) begin
        lpState_reg[i] <= msb_pkg::LP_RTI;
      end else if (unparkPend_reg && rise && tap_reg == msb_pkg::TAP_RTI) begin
        lpState_reg[i] <= msb_pkg::LP_ACT;
      end
    end
  end

  // local clock gating
  logic [9:0] tlrPulses_reg [NLP];
  logic [NLP-1:0] gate;
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NLP; i++) begin
      if (srst || lpState_reg[i] != msb_pkg::LP_TLR) begin
        tlrPulses_reg[i] <= 10'h000;
      end else if (rise && tlrPulses_reg[i] != msb_pkg::TLR_STOP_PULSES) begin
        tlrPulses_reg[i] <= tlrPulses_reg[i] + 10'h001;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NLP; i++) begin
      gate[i] = 1'b0;
      if (lpState_reg[i] == msb_pkg::LP_TLR) begin
        gate[i] = (tlrPulses_reg[i] == msb_pkg::TLR_STOP_PULSES);
      end else if (lpState_reg[i] != msb_pkg::LP_ACT) begin
        gate[i] = cntOn_reg ? cntZero : modeCfg_reg[msb_pkg::MODE_STOP_BIT];
      end
    end
  end

  // local port pins
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NLP; i++) begin
      if (srst) begin
        tckL[i] <= 1'b0;
        tmsL[i] <= 1'b1;
        tdiL[i] <= 1'b0;
      end else begin
        tckL[i] <= tckDly_reg & ~gate[i];
        if (rise || lpState_reg[i] != msb_pkg::LP_ACT) begin
          case (lpState_reg[i])
            msb_pkg::LP_TLR: tmsL[i] <= 1'b1;
            msb_pkg::LP_RTI: tmsL[i] <= 1'b0;
            msb_pkg::LP_ACT: tmsL[i] <= tmsS;
            default: tmsL[i] <= 1'b1;
          endcase
        end
        if (fall) begin
          tdiL[i] <= srcL[i];
        end
      end
    end
  end

  // backplane data output
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tdoB <= 1'b0;
      tdoBOe <= 1'b0;
    end else if (fall) begin
      tdoB <= chainOut;
      tdoBOe <= selected_reg & shifting;
    end
  end
endmodule

//--- hdl/msb_fifo.sv
// sample queue with valid and ready on both sides
`timescale 1ns/100ps
module msb_fifo #(parameter int W = 1, parameter int DEPTH = 8) (
  input wire logic clk_sys,
  input wire logic srst,
  msb_stream_if.snk inPort,
  msb_stream_if.src outPort
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign inPort.ready = (count_reg != (AW+1)'(DEPTH));
  assign outPort.valid = (count_reg != '0);
  assign outPort.data = mem[rdPtr_reg];
  assign push = inPort.valid & inPort.ready;
  assign pop = outPort.valid & outPort.ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_reg] <= inPort.data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + AW'(1);
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule

//--- hdl/msb_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module msb_sync #(parameter int W = 1) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= '0;
      pinOut <= '0;
    end else begin
      meta_reg <= pinIn;
      pinOut <= meta_reg;
    end
  end
endmodule

//--- tb/msb_bridge_chk.sv
// port checker for the scan bridge
`timescale 1ns/100ps
module msb_bridge_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic tckB,
  input wire logic tdoB,
  input wire logic tdoBOe,
  input wire logic [2:0] tckL,
  input wire logic [2:0] tmsL,
  input wire logic [2:0] tdiL
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  property p_rst_park;
    $fell(srst) |-> tmsL == 3'h7 && tckL == 3'h0 && !tdoBOe;
  endproperty
  a_rst_park: assert property (p_rst_park) else $error("ports not parked");
  property p_tdo_low;
    $changed(tdoB) |-> !tckB;
  endproperty
  a_tdo_low: assert property (p_tdo_low) else $error("tdo moved in high phase");
  property p_oe_low;
    $changed(tdoBOe) |-> !tckB;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("enable moved in high phase");
  property p_tdi_low;
    $changed(tdiL) |-> !tckB;
  endproperty
  a_tdi_low: assert property (p_tdi_low) else $error("local data moved early");
  property p_hold;
    $rose(tckB) |-> ($stable(tdoB) && $stable(tdoBOe))[*4];
  endproperty
  a_hold: assert property (p_hold) else $error("output not held");
  property p_lclk_rise;
    $rose(tckL[0]) |-> tckB;
  endproperty
  a_lclk_rise: assert property (p_lclk_rise) else $error("local clock rose alone");
  property p_lclk_fall;
    $fell(tckB) |-> ##[1:6] tckL == 3'h0;
  endproperty
  a_lclk_fall: assert property (p_lclk_fall) else $error("local clock stuck high");
  property p_lclk_quiet;
    (!tckB)[*8] |-> tckL == 3'h0;
  endproperty
  a_lclk_quiet: assert property (p_lclk_quiet) else $error("local clock runs idle");
  c_drive: cover property (tdoBOe && tdoB);
  c_lclk: cover property ($rose(tckL[0]));
  c_park: cover property (tmsL == 3'h7 && tdoBOe);
endmodule
bind msb_bridge msb_bridge_chk chk (.clk_sys(clk_sys), .srst(srst), .tckB(tckB), .tdoB(tdoB),
  .tdoBOe(tdoBOe), .tckL(tckL), .tmsL(tmsL), .tdiL(tdiL));

//--- tb/msb_master.sv
// backplane test master model
`timescale 1ns/100ps
module msb_master (
  output logic tckB,
  output logic tmsB,
  output logic tdiB,
  input wire logic tdoB,
  input wire logic tdoBOe
);
  logic lastTdo;
  initial begin
    tckB = 1'b0;
    tmsB = 1'b1;
    tdiB = 1'b0;
    lastTdo = 1'b0;
  end
  // one clock pulse, data taken at the rise, undriven line reads inverted
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tmsB = tms;
    tdiB = tdi;
    #62.5 tckB = 1'b1;
    tdo = tdoBOe ? tdoB : ~lastTdo;
    lastTdo = tdo;
    #62.5 tckB = 1'b0;
  endtask
  task automatic reset();
    logic t;
    repeat (6) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
  // scan from idle back to idle, clock stands still afterwards
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout);
    logic t;
    dout = 32'h0;
    step(1'b1, 1'b0, t);
    if (ir) step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    tdiB = ~tdiB;
  endtask
endmodule

//--- tb/test_multidrop_scan_bridge_data_regs.sv
// self-checking bench for the scan bridge data registers
`timescale 1ns/100ps
module test_multidrop_scan_bridge_data_regs;
  logic clk_sys, srst, tckB, tmsB, tdiB, outEnN, tdoB, tdoBOe, oeSeen, lclkSeen;
  logic [6:0] slotIn;
  logic [2:0] tckL, tmsL, tdiL, tdoL;
  logic [31:0] d;
  logic [15:0] s;
  int errTotal;
  int compares;
  msb_bridge uut (.clk_sys(clk_sys), .srst(srst), .tckB(tckB), .tmsB(tmsB), .tdiB(tdiB),
    .slotIn(slotIn), .outEnN(outEnN), .tdoL(tdoL), .tdoB(tdoB), .tdoBOe(tdoBOe),
    .tckL(tckL), .tmsL(tmsL), .tdiL(tdiL));
  msb_master m (.tckB(tckB), .tmsB(tmsB), .tdiB(tdiB), .tdoB(tdoB), .tdoBOe(tdoBOe));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) tdoL <= tdiL;
  always @(posedge clk_sys) if (tdoBOe === 1'b1) oeSeen <= 1'b1;
  always @(posedge clk_sys) if (tckL !== 3'h0) lclkSeen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ir(input logic [7:0] op);
    m.scan(1'b1, 8, {24'h0, op}, d);
  endtask
  task automatic dr(input int n, input logic [31:0] v);
    m.scan(1'b0, n, v, d);
  endtask
  task automatic sel();
    m.reset();
    ir(8'h15);
  endtask
  task automatic t_addr();
    logic [7:0] a [4];
    a = '{8'h15, 8'h3b, 8'h3c, 8'h3d};
    sel();
    ir(msb_pkg::OP_GRP_SEL);
    dr(2, 32'h1);
    foreach (a[i]) begin
      m.reset();
      ir(a[i]);
      oeSeen = 1'b0;
      ir(msb_pkg::OP_MODE_SEL);
      chk({31'h0, oeSeen}, {31'h0, a[i] != 8'h3d});
      if (a[i] != 8'h3d) chk(d, 32'h55);
    end
  endtask
  task automatic t_regs();
    sel();
    ir(msb_pkg::OP_MODE_SEL);
    dr(8, 32'h10);
    chk(d, 32'h01);
    dr(8, 32'h0);
    chk(d, 32'h10);
    ir(msb_pkg::OP_SAMPLE);
    dr(8, 32'h0);
    chk(d, {24'h0, outEnN, slotIn});
    ir(msb_pkg::OP_SOFT_PARK);
    chk({29'h0, tmsL}, 32'h7);
    dr(32, 32'h0);
    chk(d, msb_pkg::ID_CODE);
    ir(msb_pkg::OP_DEF_BYP);
    ir(msb_pkg::OP_SOFT_PARK);
    dr(2, 32'h3);
    chk(d, 32'h2);
  endtask
  task automatic t_sig();
    sel();
    ir(msb_pkg::OP_SIG_ON);
    ir(msb_pkg::OP_IDCODE);
    dr(32, 32'h0);
    ir(msb_pkg::OP_SIG_OFF);
    s = 16'h0;
    for (int i = 0; i < 32; i++) begin
      s = {s[14:0], 1'b0} ^ ((s[15] ^ msb_pkg::ID_CODE[i]) ? 16'h100b : 16'h0);
    end
    ir(msb_pkg::OP_SIG_SEL);
    dr(16, 32'ha5c3);
    chk(d, {16'h0, s});
    ir(msb_pkg::OP_IDCODE);
    dr(32, 32'h0);
    ir(msb_pkg::OP_SIG_SEL);
    dr(16, 32'h0);
    chk(d, 32'ha5c3);
    dr(16, 32'h0);
    chk(d, 32'h0);
  endtask
  task automatic t_cnt();
    sel();
    lclkSeen = 1'b0;
    ir(msb_pkg::OP_CNT_SEL);
    dr(32, 32'h3);
    chk(d, 32'h0);
    dr(32, 32'h3);
    chk(d, 32'h3);
    ir(msb_pkg::OP_CNT_ON);
    ir(msb_pkg::OP_MODE_SEL);
    dr(8, 32'h01);
    chk(d, 32'h81);
    ir(msb_pkg::OP_CNT_OFF);
    ir(msb_pkg::OP_MODE_SEL);
    dr(8, 32'h01);
    chk(d, 32'h01);
    chk({31'h0, lclkSeen}, 32'h0);
  endtask
  task automatic completeRun();
    $display("compares=%0d errors=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #500us;
    errTotal++;
    completeRun();
  end
  initial begin
    srst = 1'b1;
    slotIn = 7'h15;
    outEnN = 1'b1;
    tdoL = 3'h0;
    oeSeen = 1'b0;
    lclkSeen = 1'b0;
    errTotal = 0;
    compares = 0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #3;
    t_addr();
    t_regs();
    t_sig();
    t_cnt();
    completeRun();
  end
endmodule
